// [rtl/tfs_abs_compare.v]
// magnitude check: |main - aux| greater than a small threshold
// assumes unsigned results of equal width; purely combinational
`timescale 1ns/1ps
module tfs_abs_compare #(
  parameter W = 16,
  parameter TW = 3
) (
  // operands
  input wire [W-1:0] main_i,
  input wire [W-1:0] aux_i,
  input wire [TW-1:0] thr_i,
  // result
  output wire fail_o
);

  wire [W-1:0] diff;
  wire [W-1:0] thr_ext;

  // order operands so the difference never wraps
  assign diff = (main_i >= aux_i) ? (main_i - aux_i) : (aux_i - main_i);
  assign thr_ext = {{(W-TW){1'b0}}, thr_i};
  assign fail_o = (diff > thr_ext);

endmodule

// [rtl/tfs_consts.vh]
// constants for the temperature and adc compare fault status bank
// assumes a wishbone slave with 32-bit data and word-wide registers
`ifndef TFS_CONSTS_VH
`define TFS_CONSTS_VH

// register indices; byte address is four times the index
`define TFS_IDX_OVER_TEMP 12'h540
`define TFS_IDX_UNDER_TEMP 12'h541
`define TFS_IDX_PIN_CMP 12'h543
`define TFS_IDX_CELL_CMP 12'h546
`define TFS_IDX_THRESH 12'h560
`define TFS_IDX_INT_STATUS 12'h561
`define TFS_IDX_INT_MASK 12'h562

// reset values
`define TFS_RST_FLAGS 8'h00
`define TFS_RST_CELL_FLAGS 6'h00
`define TFS_RST_PIN_THR 3'h0
`define TFS_RST_CELL_THR 5'h00
`define TFS_RST_INT 4'h0

// threshold register field positions
`define TFS_PIN_THR_LSB 0
`define TFS_PIN_THR_MSB 2
`define TFS_CELL_THR_LSB 8
`define TFS_CELL_THR_MSB 12

// interrupt status bit positions
`define TFS_INT_OVER_TEMP 0
`define TFS_INT_UNDER_TEMP 1
`define TFS_INT_PIN_FAIL 2
`define TFS_INT_CELL_FAIL 3

// sizes
`define TFS_NUM_PINS 8
`define TFS_NUM_CELLS 6
`define TFS_ADC_W 16
`define TFS_PIN_THR_W 3
`define TFS_CELL_THR_W 5
`define TFS_INT_W 4

`endif

// [rtl/tfs_fault_bank.v]
// read-only fault status bank for temperature and adc compare results
// assumes comparator levels arrive asynchronously from the analog side,
// while diagnostic results and done strobes come from logic on clk_i,
// and that a bus write lands only on the edge that sees ack
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "tfs_consts.vh"

// How it works
// - over-temp register: bit n is pin n+1
// - under-temp register: bit n is pin n+1
// - pin compare register: eight bits, 1 fails
// - pin fails when difference exceeds 3-bit threshold
// - cell compare register: six bits, one per cell; word bits 7:6 reserved
// - cell fails when difference exceeds 5-bit threshold
module tfs_fault_bank (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // temperature comparators, asynchronous levels
  input wire [7:0] over_temp_i,
  input wire [7:0] under_temp_i,
  // pin diagnostic, main and auxiliary adc results
  input wire [127:0] pin_main_i,
  input wire [127:0] pin_aux_i,
  input wire pin_diag_done_i,
  // cell diagnostic, main and auxiliary cell voltages
  input wire [95:0] main_cell_voltage_i,
  input wire [95:0] aux_cell_voltage_i,
  input wire cell_diag_done_i,
  // thresholds seen by the diagnostic sequencer
  output wire [2:0] pin_compare_threshold_o,
  output wire [4:0] cell_compare_threshold_o,
  // interrupt
  output wire irq_o
);

  localparam NP = `TFS_NUM_PINS;
  localparam NC = `TFS_NUM_CELLS;
  localparam AW = `TFS_ADC_W;
  localparam IW = `TFS_INT_W;

  // bus states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  // word map; byte address is four times the index
  //   0x540 over-temperature flags, live copy, read only
  //   0x541 under-temperature flags, live copy, read only
  //   0x543 pin compare flags, loaded on the pin done pulse
  //   0x546 cell compare flags in 5:0, loaded on the cell done pulse
  //   0x560 thresholds, pin field 2:0, cell field 12:8
  //   0x561 interrupt status, write one to clear
  //   0x562 interrupt mask, a one enables the bit
  //   anything else reads zero, ignores writes, still acks

  // fault registers
  reg [7:0] over_temp_flags_reg;
  reg [7:0] under_temp_flags_reg;
  reg [7:0] pin_adc_compare_flags_reg;
  reg [5:0] cell_adc_compare_flags_reg;
  reg [7:0] over_temp_flags_next;
  reg [7:0] under_temp_flags_next;
  reg [7:0] pin_adc_compare_flags_next;
  reg [5:0] cell_adc_compare_flags_next;

  // control registers
  reg [2:0] pin_thr_reg;
  reg [4:0] cell_thr_reg;
  reg [IW-1:0] int_status_reg;
  reg [IW-1:0] int_mask_reg;
  reg [IW-1:0] int_status_next;

  // bus slave state
  reg [1:0] bus_state_reg;
  reg [1:0] bus_state_next;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;

  // synchronised comparator levels
  wire [7:0] hot_sync;
  wire [7:0] cold_sync;

  // combinational compare results
  wire [NP-1:0] pin_fail;
  wire [NC-1:0] cell_fail;

  // decoded bus access
  wire req;
  wire [11:0] idx;
  wire wr_ok;
  wire hit_over;
  wire hit_under;
  wire hit_pin;
  wire hit_cell;
  wire hit_thr;
  wire hit_ists;
  wire hit_imsk;

  // event sources for the interrupt status
  wire [IW-1:0] int_event;
  wire [IW-1:0] int_clear;

  // analog comparator levels come from outside the clock domain
  // a glitch shorter than a clock may be missed; thermal levels are
  // slow, so two flops were judged enough
  tfs_sync2 #(
    .W(8)
  ) u_hot_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(over_temp_i),
    .sync_o(hot_sync)
  );

  tfs_sync2 #(
    .W(8)
  ) u_cold_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(under_temp_i),
    .sync_o(cold_sync)
  );

  // one magnitude check per analog pin
  // threshold is zero-extended; zero fails on any difference
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp = gp + 1) begin : g_pin
      tfs_abs_compare #(
        .W(AW),
        .TW(`TFS_PIN_THR_W)
      ) u_cmp (
        .main_i(pin_main_i[gp*AW +: AW]),
        .aux_i(pin_aux_i[gp*AW +: AW]),
        .thr_i(pin_thr_reg),
        .fail_o(pin_fail[gp])
      );
    end
  endgenerate

  // one magnitude check per cell
  // five-bit threshold, same zero-extended compare as the pins
  genvar gc;
  generate
    for (gc = 0; gc < NC; gc = gc + 1) begin : g_cell
      tfs_abs_compare #(
        .W(AW),
        .TW(`TFS_CELL_THR_W)
      ) u_cmp (
        .main_i(main_cell_voltage_i[gc*AW +: AW]),
        .aux_i(aux_cell_voltage_i[gc*AW +: AW]),
        .thr_i(cell_thr_reg),
        .fail_o(cell_fail[gc])
      );
    end
  endgenerate

  // address decode; only the word index matters
  // unused address bits alias the map every 16 kbyte
  assign req = wb_cyc_i & wb_stb_i & bus_state_reg[0];
  assign idx = wb_adr_i[13:2];
  assign hit_over = (idx == `TFS_IDX_OVER_TEMP);
  assign hit_under = (idx == `TFS_IDX_UNDER_TEMP);
  assign hit_pin = (idx == `TFS_IDX_PIN_CMP);
  assign hit_cell = (idx == `TFS_IDX_CELL_CMP);
  assign hit_thr = (idx == `TFS_IDX_THRESH);
  assign hit_ists = (idx == `TFS_IDX_INT_STATUS);
  assign hit_imsk = (idx == `TFS_IDX_INT_MASK);

  // writes land on the ack edge, the edge at which the master sees
  // ack; a master that drops its strobe early never half-writes
  assign wr_ok = wb_ack_o & wb_we_i;

  // live temperature flags follow the synchronised comparators
  always @* begin
    over_temp_flags_next = hot_sync;
    under_temp_flags_next = cold_sync;
  end

  // compare flags load only when a diagnostic run completes
  // between runs they hold, so software reads the last whole result
  always @* begin
    pin_adc_compare_flags_next = pin_adc_compare_flags_reg;
    cell_adc_compare_flags_next = cell_adc_compare_flags_reg;
    if (pin_diag_done_i) begin
      pin_adc_compare_flags_next = pin_fail;
    end
    if (cell_diag_done_i) begin
      cell_adc_compare_flags_next = cell_fail;
    end
  end

  // fault registers; no bus path writes them at all
  always @(posedge clk_i) begin
    if (rst_i) begin
      over_temp_flags_reg <= `TFS_RST_FLAGS;
      under_temp_flags_reg <= `TFS_RST_FLAGS;
      pin_adc_compare_flags_reg <= `TFS_RST_FLAGS;
      cell_adc_compare_flags_reg <= `TFS_RST_CELL_FLAGS;
    end else begin
      over_temp_flags_reg <= over_temp_flags_next;
      under_temp_flags_reg <= under_temp_flags_next;
      pin_adc_compare_flags_reg <= pin_adc_compare_flags_next;
      cell_adc_compare_flags_reg <= cell_adc_compare_flags_next;
    end
  end

  // threshold register, byte lanes 0 and 1
  // a change mid-run moves the flags only at the next done pulse;
  // the sequencer sees it at once on the threshold outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_thr_reg <= `TFS_RST_PIN_THR;
      cell_thr_reg <= `TFS_RST_CELL_THR;
    end else if (wr_ok & hit_thr) begin
      if (wb_sel_i[0]) begin
        pin_thr_reg <= wb_dat_i[`TFS_PIN_THR_MSB:`TFS_PIN_THR_LSB];
      end
      if (wb_sel_i[1]) begin
        cell_thr_reg <= wb_dat_i[`TFS_CELL_THR_MSB:`TFS_CELL_THR_LSB];
      end
    end
  end

  // rising edges of the temperature flags and fails on completion
  // one bit per class: a second pin rising while one is high sets it
  assign int_event[`TFS_INT_OVER_TEMP] =
    |(over_temp_flags_next & ~over_temp_flags_reg);
  assign int_event[`TFS_INT_UNDER_TEMP] =
    |(under_temp_flags_next & ~under_temp_flags_reg);
  assign int_event[`TFS_INT_PIN_FAIL] = pin_diag_done_i & (|pin_fail);
  assign int_event[`TFS_INT_CELL_FAIL] = cell_diag_done_i & (|cell_fail);

  // write one to clear, lane 0 only
  assign int_clear = (wr_ok & hit_ists & wb_sel_i[0]) ?
    wb_dat_i[IW-1:0] : {IW{1'b0}};

  // a new event in the clearing cycle survives the clear
  always @* begin
    int_status_next = (int_status_reg & ~int_clear) | int_event;
  end

  // status register; reset clears every bit at once; a lane 0 write of ones to all four bits clears all but bits with an event that cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_status_reg <= `TFS_RST_INT;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  // mask register; a one lets the matching status bit through
  // mask writes never touch status, so masking loses no event
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_mask_reg <= `TFS_RST_INT;
    end else if (wr_ok & hit_imsk & wb_sel_i[0]) begin
      int_mask_reg <= wb_dat_i[IW-1:0];
    end
  end

  // level interrupt, combinational from two registers
  // both inputs are flops, so the pin sees no decode glitch
  assign irq_o = |(int_status_reg & int_mask_reg);

  // read multiplexer; unmapped and reserved bits read zero
  // the cell word keeps bits 7:6 at zero, they are reserved
  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit_over) begin
      rdata_next[7:0] = over_temp_flags_reg;
    end else if (hit_under) begin
      rdata_next[7:0] = under_temp_flags_reg;
    end else if (hit_pin) begin
      rdata_next[7:0] = pin_adc_compare_flags_reg;
    end else if (hit_cell) begin
      rdata_next[5:0] = cell_adc_compare_flags_reg;
    end else if (hit_thr) begin
      rdata_next[`TFS_PIN_THR_MSB:`TFS_PIN_THR_LSB] = pin_thr_reg;
      rdata_next[`TFS_CELL_THR_MSB:`TFS_CELL_THR_LSB] = cell_thr_reg;
    end else if (hit_ists) begin
      rdata_next[IW-1:0] = int_status_reg;
    end else if (hit_imsk) begin
      rdata_next[IW-1:0] = int_mask_reg;
    end
  end

  // bus handshake: ack one cycle after the request, then idle a cycle
  // a strobe held past ack is not taken again until the state is idle;
  // the master's own idle cycle keeps transfers apart
  always @* begin
    case (bus_state_reg)
      ST_IDLE: begin
        if (wb_cyc_i & wb_stb_i) begin
          bus_state_next = ST_ACK;
        end else begin
          bus_state_next = ST_IDLE;
        end
      end
      ST_ACK: begin
        bus_state_next = ST_IDLE;
      end
      default: begin
        bus_state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= ST_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // read data captured with the request so it is stable under ack
  // costs a 32-bit register but keeps dat_o still if flags move
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req) begin
      rdata_reg <= rdata_next;
    end
  end

  // ack only while the master still holds its request
  assign wb_ack_o = bus_state_reg[1] & wb_cyc_i & wb_stb_i;
  assign wb_dat_o = rdata_reg;

  // thresholds go straight to the sequencer
  assign pin_compare_threshold_o = pin_thr_reg;
  assign cell_compare_threshold_o = cell_thr_reg;

endmodule

// [rtl/tfs_sync2.v]
// two-flop synchroniser for a bundle of slow level signals
// assumes each bit changes slowly; bits are not coherent with each other
`timescale 1ns/1ps
module tfs_sync2 #(
  parameter W = 8
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // levels
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// [tb/tb.sv]
// testbench for the fault status bank over classic wishbone
// assumes tfs_fault_bank and its checker compiled before it
`timescale 1ns/1ps
module tb;
  // dut inputs, all set at time zero
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [15:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [7:0] ot = 0, ut = 0;
  logic [127:0] pm = 0, pa = 0;
  logic [95:0] cm = 0, ca = 0;
  logic pd = 0, cd = 0;
  logic [3:0] sel = 4'hf;
  wire [31:0] dat_o;
  wire ack, irq;
  wire [2:0] pthr;
  wire [4:0] cthr;
  int num_errors = 0, tests_run = 0;
  logic [15:0] fa [4] = '{16'h1500, 16'h1504, 16'h150c, 16'h1518};

  tfs_fault_bank i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .over_temp_i(ot),
    .under_temp_i(ut), .pin_main_i(pm), .pin_aux_i(pa),
    .pin_diag_done_i(pd), .main_cell_voltage_i(cm),
    .aux_cell_voltage_i(ca), .cell_diag_done_i(cd),
    .pin_compare_threshold_o(pthr), .cell_compare_threshold_o(cthr),
    .irq_o(irq));

  // 250 MHz clock
  initial forever #2 clk_i = ~clk_i;

  task finish_test;
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; waits for ack, only the watchdog ends a hang
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask

  task rd(input logic [15:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(rdat, e);
  endtask

  // both diagnostics; diffs run both signs so abs handling is hit
  task diag(input logic [2:0] pt, input logic [4:0] ct);
    logic [7:0] pe, ce;
    logic [127:0] pv, av;
    logic [95:0] cv, cw;
    int dm;
    ce = 0;
    wb(1, 16'h1580, {19'h0, ct, 5'h0, pt});
    for (int i = 0; i < 8; i++) begin
      pv[16*i+:16] = 16'h8000 + 16'(i*i);
      av[16*i+:16] = 16'h8000 + 16'(3*i);
      dm = i*i - 3*i;
      pe[i] = (dm < 0 ? -dm : dm) > pt;
    end
    for (int i = 0; i < 6; i++) begin
      cv[16*i+:16] = 16'h8000 + 16'(2*i*i);
      cw[16*i+:16] = 16'h8000 + 16'(4*i);
      dm = 2*i*i - 4*i;
      ce[i] = (dm < 0 ? -dm : dm) > ct;
    end
    pm <= pv;
    pa <= av;
    cm <= cv;
    ca <= cw;
    pd <= 1;
    cd <= 1;
    @(posedge clk_i);
    pd <= 0;
    cd <= 0;
    @(posedge clk_i);
    chk({pthr, cthr}, {pt, ct});
    rd(16'h150c, {24'h0, pe});
    rd(16'h1518, {24'h0, ce});
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rd(fa[i], 32'h0);
    ot <= 8'h81;
    ut <= 8'h7e;
    repeat (5) @(posedge clk_i);
    rd(16'h1500, 32'h81);
    rd(16'h1504, 32'h7e);
    // writes to status words must not land
    for (int i = 0; i < 4; i++) wb(1, fa[i], 32'hffffffff);
    rd(16'h1500, 32'h81);
    rd(16'h1504, 32'h7e);
    rd(16'h150c, 32'h0);
    rd(16'h1518, 32'h0);
    ot <= 8'h01;
    ut <= 8'h80;
    repeat (5) @(posedge clk_i);
    rd(16'h1500, 32'h01);
    rd(16'h1504, 32'h80);
    // a diff equal to the threshold passes
    diag(3'h2, 5'h10);
    diag(3'h3, 5'h06);
    diag(3'h7, 5'h1f);
    // sticky status, mask, write one to clear
    rd(16'h1584, 32'hf);
    chk(irq, 1'b0);
    wb(1, 16'h1588, 32'h4);
    chk(irq, 1'b1);
    wb(1, 16'h1584, 32'hf);
    rd(16'h1584, 32'h0);
    chk(irq, 1'b0);
    diag(3'h7, 5'h1f);
    chk(irq, 1'b1);
    rd(16'h1588, 32'h4);
    wb(1, 16'h1588, 32'h0);
    chk(irq, 1'b0);
    // unmapped places read zero yet are acked
    wb(1, 16'h1590, 32'hffffffff);
    rd(16'h1590, 32'h0);
    rd(16'h1508, 32'h0);
    // lane 0 alone moves only the pin threshold
    sel <= 4'h1;
    wb(1, 16'h1580, 32'h0);
    sel <= 4'hf;
    chk({pthr, cthr}, {3'h0, 5'h1f});
    // reset in mid-run clears loaded flags and thresholds
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd(16'h1500, 32'h0);
    rd(16'h150c, 32'h0);
    chk({pthr, cthr}, 8'h00);
    chk(irq, 1'b0);
    finish_test;
  end

  // watchdog well beyond the roughly 150 cycles needed
  initial begin
    repeat (4000) @(posedge clk_i);
    num_errors++;
    finish_test;
  end
endmodule

bind tfs_fault_bank tfs_fault_bank_asserts i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .over_temp_i(over_temp_i),
  .pin_compare_threshold_o(pin_compare_threshold_o),
  .cell_compare_threshold_o(cell_compare_threshold_o), .irq_o(irq_o));

// [tb/tfs_fault_bank_asserts.sv]
// checker for the fault status bank: bus timing and flag reads
// assumes binding to tfs_fault_bank; one clock, sync reset
`timescale 1ns/1ps
module tfs_fault_bank_asserts (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // flags and outputs
  input wire [7:0] over_temp_i,
  input wire [2:0] pin_compare_threshold_o,
  input wire [4:0] cell_compare_threshold_o,
  input wire irq_o
);
  // request taken: ack low means the slave is idle
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = tk && !wb_we_i;
  wire [11:0] ix = wb_adr_i[13:2];
  wire [7:0] thr_w = {wb_dat_i[12:8], wb_dat_i[2:0]};

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_after_req_a: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
    else $error("ack late");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_in_cycle_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without cycle");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
    else $error("outputs live in reset");
  thr_write_a: assert property (wb_ack_o && wb_we_i &&
    ix == 12'h560 && wb_sel_i[1:0] == 2'h3 |=> {cell_compare_threshold_o,
    pin_compare_threshold_o} == $past(thr_w))
    else $error("threshold not written");
  cell_reserved_a: assert property (rd && ix == 12'h546
    |=> wb_dat_o[31:6] == 26'h0) else $error("reserved bits set");
  over_temp_read_a: assert property ($stable(over_temp_i) [*4] ##0
    (rd && ix == 12'h540) |=> wb_dat_o == {24'h0, $past(over_temp_i)})
    else $error("over temp word wrong");
  unmapped_read_a: assert property (rd && (ix < 12'h540 || ix > 12'h562)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule
